// ==== hdl/ple_defines.vh ====
// ple_defines.vh : constants of the postfix logic equation engine
`ifndef PLE_DEFINES_VH
`define PLE_DEFINES_VH
// parameter word layout: [15:12] opcode, [11:0] argument
`define PLE_OP_MSB      15
`define PLE_OP_LSB      12
`define PLE_ARG_MSB     11
`define PLE_ARG_LSB     0
// opcodes
`define PLE_OP_END      4'h0
`define PLE_OP_OPERAND  4'h1
`define PLE_OP_NOT      4'h2
`define PLE_OP_OR       4'h3
`define PLE_OP_AND      4'h4
`define PLE_OP_NOR      4'h5
`define PLE_OP_NAND     4'h6
`define PLE_OP_XOR      4'h7
`define PLE_OP_LATCH    4'h8
`define PLE_OP_TIMER    4'h9
`define PLE_OP_VOUT     4'hA
// operand sources in argument [7:6]; index in [5:0]
`define PLE_SRC_EXT     2'h0
`define PLE_SRC_VOUT    2'h1
`define PLE_SRC_TIMER   2'h2
`define PLE_SRC_CONST   2'h3
// sizes
`define PLE_LIST_DEPTH  512
`define PLE_ADDR_W      9
`define PLE_STACK_DEPTH 16
`define PLE_N_TIMERS    32
`define PLE_N_VOUTS     64
`define PLE_N_LATCHES   32
`define PLE_N_EXT       64
`define PLE_MIN_GATE_IN 5'h02
`define PLE_MAX_GATE_IN 5'h10
// evaluation pass period in clocks (40.96 us at 50 MHz): far more than four
// passes per power cycle, and still room for a full 512-entry list per period
`define PLE_PASS_CYCLES 2048
`endif

// ==== hdl/ple_engine.v ====
// ple_engine.v : postfix logic equation engine, top level
// Functional notes
// - operands precede the operator using them
// - one result; reuse needs a virtual output
// - virtual output assignment ends the equation
// - duplicate timer or assignment is syntax error
// - evaluate parameters strictly in list order
// - and/or/nor/nand take 2 to 16 inputs
// - xor takes two, true if exactly one
// - latch is reset dominant
// - newest is reset, next older is set
// - set latch holds until reset
// - latches cleared at power up
// - settings change recompiles and clears latches
// - 32 timers started by preceding result
// - 64 virtual outputs take preceding result
// - gate truth functions as tabulated
// - stop evaluation at first end marker
// - whole list evaluated four times per cycle
`timescale 1ns/10ps
`include "ple_defines.vh"
module ple_engine (
  input  wire        SYS_CLK,
  input  wire        NRST,
  input  wire        SETTINGS_CHANGED,  // pulse: new setting value entered
  input  wire [15:0] PARAM_DATA,        // parameter word at PARAM_ADDR
  input  wire [63:0] EXT_OPERANDS,      // element and contact states
  input  wire [31:0] TIMER_OUT,         // outputs of the 32 timers
  output reg  [8:0]  PARAM_ADDR,        // list index being read
  output reg  [31:0] TIMER_START,       // timer start inputs
  output reg  [63:0] VIRT_OUT,          // virtual outputs of last pass
  output reg         PASS_DONE,         // pulse: pass finished
  output reg         SYNTAX_ERR,        // level: list broke a rule
  output reg         BUSY               // level: compile scan or pass in progress
);
  // states
  localparam ST_IDLE  = 2'h0;
  localparam ST_CHECK = 2'h1;           // compile: duplicate scan
  localparam ST_EVAL  = 2'h2;
  localparam ST_WAIT  = 2'h3;           // fetch latency slot

  reg [1:0]  state_r;
  reg [21:0] tick_r;                    // pass period counter
  reg [8:0]  pc_r;                      // current parameter index
  reg [63:0] vout_work_r;               // current-pass virtual outputs
  reg [63:0] vout_seen_r;               // assigned already this pass
  reg [31:0] tmr_seen_r;                // timer used already (compile)
  reg [63:0] vas_seen_r;                // assignment used (compile)
  reg [31:0] latch_r;                   // latch states, volatile
  reg [4:0]  latch_idx_r;               // next latch instance
  reg        compiled_r;                // list compiled since change
  reg        st_clear;                  // stack control, comb
  reg [4:0]  st_pop;
  reg        st_push;
  reg        st_val;
  wire [15:0] st_bits;
  wire [4:0]  st_depth;
  wire        st_ovf;
  wire [3:0]  op   = PARAM_DATA[`PLE_OP_MSB:`PLE_OP_LSB];
  wire [11:0] arg  = PARAM_DATA[`PLE_ARG_MSB:`PLE_ARG_LSB];
  wire [4:0]  nin  = arg[4:0];          // gate input count
  wire [5:0]  idx  = arg[5:0];

  // mask of the n newest stack bits
  function [15:0] in_mask;
    input [4:0] n;
    begin
      in_mask = (n >= 5'h10) ? 16'hFFFF : ((16'h0001 << n) - 16'h0001);
    end
  endfunction

  // operand fetch; virtual outputs read early see the last pass
  function fetch_operand;
    input [11:0] a;
    input [63:0] ext;
    input [31:0] tmr;
    input [63:0] work;
    input [63:0] seen;
    input [63:0] prev;
    begin
      case (a[7:6])
        `PLE_SRC_EXT:   fetch_operand = ext[a[5:0]];
        `PLE_SRC_VOUT:  fetch_operand = seen[a[5:0]] ? work[a[5:0]] : prev[a[5:0]];
        `PLE_SRC_TIMER: fetch_operand = tmr[a[4:0]];
        default:        fetch_operand = a[0];                  // fixed on/off
      endcase
    end
  endfunction

  wire [15:0] gate_in = st_bits & in_mask(nin);
  wire        gate_ok = (nin >= `PLE_MIN_GATE_IN) && (nin <= `PLE_MAX_GATE_IN) && (st_depth >= nin);
  wire        l_set   = st_bits[1];
  wire        l_rst   = st_bits[0];
  wire        l_nxt   = ~l_rst & (l_set | latch_r[latch_idx_r]);

  ple_stack u_stack (
    .clk      (SYS_CLK),
    .nrst     (NRST),
    .clear    (st_clear),
    .pop_n    (st_pop),
    .push     (st_push),
    .push_val (st_val),
    .top_bits (st_bits),
    .depth    (st_depth),
    .overflow (st_ovf)
  );

  // one parameter per step; operators consume newest results only
  always @* begin
    st_clear = 1'b0;
    st_pop   = 5'h00;
    st_push  = 1'b0;
    st_val   = 1'b0;
    if (state_r == ST_IDLE) begin
      st_clear = 1'b1;
    end else if (state_r == ST_EVAL) begin
      case (op)
        `PLE_OP_OPERAND: begin
          st_push = 1'b1;
          st_val  = fetch_operand(arg, EXT_OPERANDS, TIMER_OUT, vout_work_r, vout_seen_r, VIRT_OUT);
        end
        `PLE_OP_NOT: begin
          st_pop = 5'h01;
          st_push = 1'b1;
          st_val = ~st_bits[0];
        end
        `PLE_OP_OR, `PLE_OP_AND, `PLE_OP_NOR, `PLE_OP_NAND: begin
          st_pop  = gate_ok ? nin : 5'h00;
          st_push = 1'b1;
          case (op)
            `PLE_OP_OR:  st_val = |gate_in;
            `PLE_OP_AND: st_val = (gate_in == in_mask(nin));
            `PLE_OP_NOR: st_val = ~|gate_in;
            default:     st_val = (gate_in != in_mask(nin));
          endcase
        end
        `PLE_OP_XOR: begin
          st_pop = 5'h02;
          st_push = 1'b1;
          st_val = st_bits[0] ^ st_bits[1];
        end
        `PLE_OP_LATCH: begin
          st_pop = 5'h02;
          st_push = 1'b1;
          st_val = l_nxt;
        end
        `PLE_OP_TIMER: begin
          st_pop = 5'h01;
          st_push = 1'b1;
          st_val = TIMER_OUT[idx[4:0]];
        end
        `PLE_OP_VOUT: st_clear = 1'b1;
        default: st_clear = 1'b0;
      endcase
    end
  end

  // sequencer: compile scan after a change, then periodic passes
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r     <= ST_IDLE;
      tick_r      <= 22'h000000;
      pc_r        <= 9'h000;
      PARAM_ADDR  <= 9'h000;
      vout_work_r <= 64'h0;
      vout_seen_r <= 64'h0;
      tmr_seen_r  <= 32'h0;
      vas_seen_r  <= 64'h0;
      latch_r     <= 32'h0;
      latch_idx_r <= 5'h00;
      compiled_r  <= 1'b0;
      TIMER_START <= 32'h0;
      VIRT_OUT    <= 64'h0;
      PASS_DONE   <= 1'b0;
      SYNTAX_ERR  <= 1'b0;
      BUSY        <= 1'b0;
    end else begin
      PASS_DONE <= 1'b0;
      tick_r <= (tick_r == `PLE_PASS_CYCLES - 1) ? 22'h000000 : tick_r + 22'h000001;
      if (SETTINGS_CHANGED) begin
        // recompile: abandon pass and clear all latch memory
        state_r     <= ST_IDLE;
        latch_r     <= 32'h0;
        compiled_r  <= 1'b0;
        BUSY        <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (!compiled_r) begin
              state_r    <= ST_CHECK;
              tmr_seen_r <= 32'h0;
              vas_seen_r <= 64'h0;
              SYNTAX_ERR <= 1'b0;
              pc_r       <= 9'h000;
              PARAM_ADDR <= 9'h000;
              BUSY       <= 1'b1;
            end else if (tick_r == 22'h000000) begin
              state_r     <= ST_WAIT;
              pc_r        <= 9'h000;
              PARAM_ADDR  <= 9'h000;
              vout_seen_r <= 64'h0;
              vout_work_r <= VIRT_OUT;
              latch_idx_r <= 5'h00;
              BUSY        <= 1'b1;
            end
          end
          ST_CHECK: begin
            // duplicate timers or assignments are flagged
            if (op == `PLE_OP_TIMER) begin
              if (tmr_seen_r[idx[4:0]]) SYNTAX_ERR <= 1'b1;
              tmr_seen_r[idx[4:0]] <= 1'b1;
            end
            if (op == `PLE_OP_VOUT) begin
              if (vas_seen_r[idx]) SYNTAX_ERR <= 1'b1;
              vas_seen_r[idx] <= 1'b1;
            end
            if (op == `PLE_OP_END || pc_r == `PLE_LIST_DEPTH - 1) begin
              state_r    <= ST_IDLE;
              compiled_r <= 1'b1;
              BUSY       <= 1'b0;
            end else begin
              pc_r       <= pc_r + 9'h001;
              PARAM_ADDR <= pc_r + 9'h001;
            end
          end
          ST_WAIT: begin
            // overflow pulse of the last push lands here, one step late
            state_r <= ST_EVAL;
            if (st_ovf)
              SYNTAX_ERR <= 1'b1;
          end
          ST_EVAL: begin
            // gate with too few pending results is a syntax error
            if ((op >= `PLE_OP_OR && op <= `PLE_OP_NAND && !gate_ok) ||
                ((op == `PLE_OP_XOR || op == `PLE_OP_LATCH) && st_depth < 5'h02) ||
                ((op == `PLE_OP_NOT || op == `PLE_OP_TIMER || op == `PLE_OP_VOUT) && st_depth == 5'h00) ||
                st_ovf)
              SYNTAX_ERR <= 1'b1;
            if (op == `PLE_OP_LATCH) begin
              latch_r[latch_idx_r] <= l_nxt;
              latch_idx_r <= latch_idx_r + 5'h01;
            end
            if (op == `PLE_OP_TIMER)
              TIMER_START[idx[4:0]] <= st_bits[0];
            if (op == `PLE_OP_VOUT) begin
              vout_work_r[idx] <= st_bits[0];
              vout_seen_r[idx] <= 1'b1;
            end
            if (op == `PLE_OP_END || pc_r == `PLE_LIST_DEPTH - 1) begin
              state_r   <= ST_IDLE;
              VIRT_OUT  <= (op == `PLE_OP_VOUT) ? (vout_work_r | ({63'h0, 1'b1} << idx)) &
                           ~(({63'h0, ~st_bits[0]}) << idx) : vout_work_r;
              PASS_DONE <= 1'b1;
              BUSY      <= 1'b0;
            end else begin
              pc_r       <= pc_r + 9'h001;
              PARAM_ADDR <= pc_r + 9'h001;
              state_r    <= ST_WAIT;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // ple_engine

// ==== hdl/ple_stack.v ====
// ple_stack.v : pending-result stack of the equation engine
`timescale 1ns/10ps
`include "ple_defines.vh"
module ple_stack (
  input  wire        clk,
  input  wire        nrst,
  input  wire        clear,     // drop all pending results
  input  wire [4:0]  pop_n,     // results consumed this step
  input  wire        push,      // push one new result
  input  wire        push_val,
  output wire [15:0] top_bits,  // bit 0 is newest result
  output wire [4:0]  depth,
  output reg         overflow   // pulse: push onto full stack
);
  reg [15:0] bits_r;            // shift register, newest at bit 0
  reg [4:0]  depth_r;           // pending count
  reg [15:0] bits_nxt;
  reg [4:0]  depth_nxt;
  assign top_bits = bits_r;
  assign depth    = depth_r;

  // pop then push; consumed bits shift out of the bottom
  always @* begin
    bits_nxt  = bits_r >> pop_n;
    depth_nxt = depth_r - pop_n;
    if (push) begin
      bits_nxt  = {bits_nxt[14:0], push_val};
      depth_nxt = (depth_nxt == 5'h10) ? depth_nxt : depth_nxt + 5'h01;
    end
    if (clear) begin
      bits_nxt  = 16'h0000;
      depth_nxt = 5'h00;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bits_r   <= 16'h0000;
      depth_r  <= 5'h00;
      overflow <= 1'b0;
    end else begin
      bits_r   <= bits_nxt;
      depth_r  <= depth_nxt;
      overflow <= push & ~clear & ((depth_r - pop_n) == 5'h10);
    end
  end
endmodule // ple_stack

// ==== test/ple_engine_asserts.sv ====
// ple_engine_asserts.sv : port checks on the equation engine
`timescale 1ns/10ps
`include "ple_defines.vh"
module ple_engine_asserts (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        SETTINGS_CHANGED,
  input wire logic [8:0]  PARAM_ADDR,
  input wire logic [31:0] TIMER_START,
  input wire logic [63:0] VIRT_OUT,
  input wire logic        PASS_DONE,
  input wire logic        SYNTAX_ERR,
  input wire logic        BUSY
);
  // pass period plus slack for a compile scan and a full evaluation
  localparam int GAP_MAX = `PLE_PASS_CYCLES + 2048;
  logic [17:0] gap_r;  // cycles since the last pass end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // restart the gap at each pass end; a settings change delays the next pass
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST)
      gap_r <= 18'h00000;
    else if (PASS_DONE || SETTINGS_CHANGED)
      gap_r <= 18'h00000;
    else
      gap_r <= gap_r + 18'h00001;
  end
  property p_rst_quiet;
    $rose(NRST) |-> !BUSY && !PASS_DONE && !SYNTAX_ERR && VIRT_OUT == 64'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
  property p_done_pulse;
    PASS_DONE |=> !PASS_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("pass end longer than one cycle");
  property p_done_idle;
    PASS_DONE |-> !BUSY && $past(BUSY);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("pass end without busy pass");
  property p_vout_stable;
    !PASS_DONE && !$past(SETTINGS_CHANGED) |-> $stable(VIRT_OUT);
  endproperty
  a_vout_stable: assert property (p_vout_stable) else $error("virtual outputs moved mid pass");
  property p_addr_step;
    BUSY && $changed(PARAM_ADDR) && PARAM_ADDR != 9'h000 && !$past(SETTINGS_CHANGED)
      |-> PARAM_ADDR == $past(PARAM_ADDR) + 9'h001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("list not walked in order");
  property p_rate;
    gap_r < GAP_MAX;
  endproperty
  a_rate: assert property (p_rate) else $error("evaluation pass overdue");
  property p_recompile;
    SETTINGS_CHANGED |-> ##[1:2] BUSY;
  endproperty
  a_recompile: assert property (p_recompile) else $error("no recompile on settings change");
  property p_abort;
    SETTINGS_CHANGED |=> !PASS_DONE;
  endproperty
  a_abort: assert property (p_abort) else $error("pass committed after settings change");
  property p_timer_pass;
    $changed(TIMER_START) |-> $past(BUSY);
  endproperty
  a_timer_pass: assert property (p_timer_pass) else $error("timer start moved outside a pass");
  c_pass: cover property (PASS_DONE);
  c_err: cover property ($rose(SYNTAX_ERR));
  c_change: cover property (SETTINGS_CHANGED ##[1:2] BUSY);
endmodule // ple_engine_asserts

// ==== test/ple_engine_tb.sv ====
// ple_engine_tb.sv : self-checking bench for the equation engine
`timescale 1ns/10ps
`include "ple_defines.vh"
module ple_engine_tb;
  logic        SYS_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        SETTINGS_CHANGED = 1'b0;
  logic [63:0] EXT_OPERANDS = 64'h0;
  wire  [15:0] PARAM_DATA;
  wire  [31:0] TIMER_OUT;
  wire  [8:0]  PARAM_ADDR;
  wire  [31:0] TIMER_START;
  wire  [63:0] VIRT_OUT;
  wire         PASS_DONE;
  wire         SYNTAX_ERR;
  wire         BUSY;
  int          num_errors = 0;
  int          total_checks = 0;
  int          n = 0;       // next free list index
  int          end_at = 0;  // index of the end marker
  // the pass period is fixed in the header, so each pass costs 2048 cycles
  always #10 SYS_CLK = ~SYS_CLK;
  ple_engine DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .SETTINGS_CHANGED(SETTINGS_CHANGED),
    .PARAM_DATA(PARAM_DATA), .EXT_OPERANDS(EXT_OPERANDS), .TIMER_OUT(TIMER_OUT),
    .PARAM_ADDR(PARAM_ADDR), .TIMER_START(TIMER_START), .VIRT_OUT(VIRT_OUT),
    .PASS_DONE(PASS_DONE), .SYNTAX_ERR(SYNTAX_ERR), .BUSY(BUSY));
  ple_far_model FAR (.clk(SYS_CLK), .param_addr(PARAM_ADDR), .timer_start(TIMER_START),
    .param_data(PARAM_DATA), .timer_out(TIMER_OUT));
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task put(input logic [3:0] op, input logic [11:0] arg);
    FAR.list_r[n] = {op, arg};
    n++;
  endtask
  // expected gate outputs on virtual outputs 0..6
  function logic [63:0] gates(input logic [4:0] e);
    gates = 64'h0;
    gates[0] = e[0] ^ e[1];
    gates[1] = e[0] & e[1];
    gates[2] = e[0] | e[1];
    gates[3] = ~(e[0] | e[1]);
    gates[4] = ~(e[0] & e[1]);
    gates[5] = ~e[0];
    gates[6] = 1'b1;
  endfunction
  // list: five two-input gates, not, and of 16, latch, timer, feedback, end
  task build;
    logic [3:0] g [5];
    g = '{`PLE_OP_XOR, `PLE_OP_AND, `PLE_OP_OR, `PLE_OP_NOR, `PLE_OP_NAND};
    for (int k = 0; k < 5; k++) begin
      put(`PLE_OP_OPERAND, 12'h000);
      put(`PLE_OP_OPERAND, 12'h001);
      put(g[k], 12'h002);
      put(`PLE_OP_VOUT, 12'(k));
    end
    put(`PLE_OP_OPERAND, 12'h000);
    put(`PLE_OP_NOT, 12'h000);
    put(`PLE_OP_VOUT, 12'h005);
    for (int k = 0; k < 16; k++) put(`PLE_OP_OPERAND, 12'h0C1);
    put(`PLE_OP_AND, 12'h010);
    put(`PLE_OP_VOUT, 12'h006);
    put(`PLE_OP_OPERAND, 12'h002);
    put(`PLE_OP_OPERAND, 12'h003);
    put(`PLE_OP_LATCH, 12'h000);
    put(`PLE_OP_VOUT, 12'h007);
    put(`PLE_OP_OPERAND, 12'h004);
    put(`PLE_OP_TIMER, 12'h005);
    put(`PLE_OP_VOUT, 12'h008);
    put(`PLE_OP_OPERAND, 12'h049);
    put(`PLE_OP_VOUT, 12'h00A);
    put(`PLE_OP_OPERAND, 12'h0C1);
    put(`PLE_OP_VOUT, 12'h009);
    end_at = n;
    put(`PLE_OP_END, 12'h000);
    put(`PLE_OP_OPERAND, 12'h0C1);
    put(`PLE_OP_VOUT, 12'h00B);
  endtask
  // set operands right after a pass end, then wait for the next one
  task run(input logic [4:0] e);
    int i;
    EXT_OPERANDS = {59'h0, e};
    @(negedge SYS_CLK);
    for (i = 0; i < 5000 && PASS_DONE !== 1'b1; i++) @(negedge SYS_CLK);
    if (i == 5000) begin
      chk("PASS_DONE", 64'h1, 64'h0);
      stop_test;
    end
    chk("gates", gates(e), VIRT_OUT & 64'h7F);
  endtask
  task t_reset;
    repeat (10) @(negedge SYS_CLK);
    chk("reset outputs", 64'h0, VIRT_OUT | {PASS_DONE, BUSY, SYNTAX_ERR});
    NRST = 1'b1;
  endtask
  task t_first;
    run(5'b10101);
    chk("latch set", 64'h1, VIRT_OUT[7]);
    chk("feedback", 64'h200, VIRT_OUT & 64'h600);
    chk("after end", 64'h0, VIRT_OUT[11]);
    chk("timer start", 64'h1, TIMER_START[5]);
    chk("syntax ok", 64'h0, SYNTAX_ERR);
  endtask
  task t_hold;
    run(5'b10011);
    chk("latch hold", 64'h1, VIRT_OUT[7]);
    chk("timer out", 64'h1, VIRT_OUT[8]);
    chk("feedback", 64'h600, VIRT_OUT & 64'h600);
  endtask
  task t_clear;
    SETTINGS_CHANGED = 1'b1;
    @(negedge SYS_CLK);
    SETTINGS_CHANGED = 1'b0;
    run(5'b00000);
    chk("latch cleared", 64'h0, VIRT_OUT[7]);
    chk("timer stop", 64'h0, TIMER_START[5]);
  endtask
  task t_resetdom;
    run(5'b01100);
    chk("reset wins", 64'h0, VIRT_OUT[7]);
  endtask
  // set the latch, then cycle power mid run: latch memory must not survive
  task t_power;
    run(5'b00100);
    chk("latch set again", 64'h1, VIRT_OUT[7]);
    NRST = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    chk("power off", 64'h0, VIRT_OUT | TIMER_START | {PASS_DONE, BUSY});
    NRST = 1'b1;
    run(5'b00000);
    chk("latch volatile", 64'h0, VIRT_OUT[7]);
  endtask
  // second assignment of virtual output 0 must be refused
  task t_dup;
    int i;
    n = end_at;
    put(`PLE_OP_OPERAND, 12'h0C1);
    put(`PLE_OP_VOUT, 12'h000);
    put(`PLE_OP_END, 12'h000);
    SETTINGS_CHANGED = 1'b1;
    @(negedge SYS_CLK);
    SETTINGS_CHANGED = 1'b0;
    for (i = 0; i < 2000 && SYNTAX_ERR !== 1'b1; i++) @(negedge SYS_CLK);
    chk("duplicate", 64'h1, SYNTAX_ERR);
  endtask
  initial begin
    // load after the model clears its list at time zero
    @(negedge SYS_CLK);
    build;
    EXT_OPERANDS = 64'h15;
    t_reset;
    t_first;
    t_hold;
    t_clear;
    t_resetdom;
    t_power;
    t_dup;
    stop_test;
  end
endmodule // ple_engine_tb
bind ple_engine ple_engine_asserts u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .SETTINGS_CHANGED(SETTINGS_CHANGED), .PARAM_ADDR(PARAM_ADDR), .TIMER_START(TIMER_START),
  .VIRT_OUT(VIRT_OUT), .PASS_DONE(PASS_DONE), .SYNTAX_ERR(SYNTAX_ERR), .BUSY(BUSY));

// ==== test/ple_far_model.sv ====
// ple_far_model.sv : parameter list memory and timers beside the engine
`timescale 1ns/10ps
module ple_far_model (
  input  wire logic        clk,
  input  wire logic [8:0]  param_addr,
  input  wire logic [31:0] timer_start,
  output logic      [15:0] param_data,
  output logic      [31:0] timer_out
);
  logic [15:0] list_r [0:511];  // list entries, loaded by the bench
  // unused entries read as end markers, as after a fresh settings load
  initial begin
    for (int i = 0; i < 512; i++) list_r[i] = 16'h0000;
  end
  assign param_data = list_r[param_addr];  // same-cycle read
  // zero pickup and dropout delay: output follows start one cycle late
  always @(posedge clk) begin
    timer_out <= timer_start;
  end
endmodule // ple_far_model
